// ---- pkg/fault_bank_consts.svh ----
// constants for the channel fault status register bank
// assumes 8-bit register offsets with the global base taken as zero
`ifndef FAULT_BANK_CONSTS_SVH
`define FAULT_BANK_CONSTS_SVH
`define BASE_ADDR          8'h00
`define OFS_OL_ON_EN       8'h0E
`define OFS_OVL_CLEAR      8'h0F
`define OFS_STATUS0        8'h10
`define OFS_OVL_FLAGS      8'h12
`define OFS_OL_OFF_FLAGS   8'h13
`define OFS_OL_ON_FLAGS    8'h14
`define OFS_SHORT_FLAGS    8'h15
`define STATUS0_ON_ERR_BIT 1
`define STATUS0_OFF_ERR_BIT 0
`define FLAGS_RESET        8'h00
`endif

// ---- pkg/fault_bank_pkg.sv ----
// types for the channel fault status register bank
// assumes eight channels, one flag bit per channel
package fault_bank_pkg;
    typedef logic [7:0] chan_t;
    // raw fault inputs from the detection circuits
    typedef struct packed {
        chan_t overload;
        chan_t open_off;
        chan_t open_on;
        chan_t short_gb;
    } fault_in_s;
    // register access request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
endpackage : fault_bank_pkg

// ---- hdl/flag_latch.sv ----
// one bank of per-channel sticky fault flags
// assumes synchronous fault inputs and one-cycle clear strobes
`timescale 1ns/1ps
module flag_latch #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             clk_en,
    // events and clears
    input  wire logic [WIDTH-1:0] fault,
    input  wire logic [WIDTH-1:0] clear,
    // latched flags
    output logic      [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] flags_r;
    logic [WIDTH-1:0] flags_nxt;

    // per bit: a fault sets, a clear drops, a live fault wins over clear
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            flags_nxt[i] = (flags_r[i] & ~clear[i]) | fault[i];
        end
    end

    // register the flags
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            flags_r <= '0;
        end else if (clk_en) begin
            flags_r <= flags_nxt;
        end
    end

    assign flags = flags_r;
endmodule : flag_latch

// ---- hdl/fault_status_bank.sv ----
// channel fault status register bank with status summary
// assumes a decoded register port already extracted from the serial frame
// a read answers one cycle later; writes have no answer
// all state freezes while clk_en is low, except for reset
`timescale 1ns/1ps
`include "fault_bank_consts.svh"
module fault_status_bank (
    // clock, reset, enable
    input  wire logic                       core_clk,
    input  wire logic                       rstn,
    input  wire logic                       clk_en,
    // detection inputs and driver state
    input  wire fault_bank_pkg::fault_in_s  fault_in,
    input  wire fault_bank_pkg::chan_t      driver_on,
    // register port
    input  wire fault_bank_pkg::reg_req_s   req,
    output logic [7:0]                      rdata,
    output logic                            rvalid,
    // direct views
    output logic                            any_overload,
    output fault_bank_pkg::chan_t           ol_on_enable
);
    // latched flag banks
    fault_bank_pkg::chan_t      ovl_flags;
    fault_bank_pkg::chan_t      off_flags;
    fault_bank_pkg::chan_t      on_flags;
    fault_bank_pkg::chan_t      sh_flags;

    // per-channel set terms, qualified by driver state except for overload
    wire fault_bank_pkg::chan_t ovl_set;
    wire fault_bank_pkg::chan_t off_set;
    wire fault_bank_pkg::chan_t on_set;
    wire fault_bank_pkg::chan_t sh_set;

    // per-channel clear strobes
    wire fault_bank_pkg::chan_t ovl_clr;
    wire fault_bank_pkg::chan_t off_clr;
    wire fault_bank_pkg::chan_t on_clr;
    wire fault_bank_pkg::chan_t sh_clr;

    // on-state open-load enable register
    fault_bank_pkg::chan_t      en_r;
    fault_bank_pkg::chan_t      en_nxt;

    // read answer registers
    logic [7:0]                 rdata_r;
    logic [7:0]                 rdata_nxt;
    logic                       rvalid_r;
    logic                       rvalid_nxt;

    // overload summary register
    logic                       sum_r;
    logic                       sum_nxt;

    // address decode results
    logic                       hit_ovl;
    logic                       hit_off;
    logic                       hit_on;
    logic                       hit_sh;
    logic                       hit_en;
    logic                       hit_clr;
    logic                       hit_sta;

    // decode at offsets from a zero base
    always_comb begin
        hit_ovl = (req.addr == (`BASE_ADDR + `OFS_OVL_FLAGS));
        hit_off = (req.addr == (`BASE_ADDR + `OFS_OL_OFF_FLAGS));
        hit_on  = (req.addr == (`BASE_ADDR + `OFS_OL_ON_FLAGS));
        hit_sh  = (req.addr == (`BASE_ADDR + `OFS_SHORT_FLAGS));
        hit_en  = (req.addr == (`BASE_ADDR + `OFS_OL_ON_EN));
        hit_clr = (req.addr == (`BASE_ADDR + `OFS_OVL_CLEAR));
        hit_sta = (req.addr == (`BASE_ADDR + `OFS_STATUS0));
    end

    // per channel: which faults may latch and which bits a request clears
    // the set terms stay levels, so a fault still present keeps its flag
    for (genvar ch = 0; ch < 8; ch++) begin : g_chan
        // overload latches whatever the driver state
        assign ovl_set[ch] = fault_in.overload[ch];
        // off-state checks count only while the driver is off
        assign off_set[ch] = fault_in.open_off[ch] & ~driver_on[ch];
        assign sh_set[ch]  = fault_in.short_gb[ch] & ~driver_on[ch];
        // on-state open load needs the driver on and its enable bit set
        assign on_set[ch]  = fault_in.open_on[ch] & driver_on[ch] & en_r[ch];
        // write-one clear for overload, whole-register read clear for the rest
        assign ovl_clr[ch] = req.wr & hit_clr & req.wdata[ch];
        assign off_clr[ch] = req.rd & hit_off;
        assign on_clr[ch]  = req.rd & hit_on;
        assign sh_clr[ch]  = req.rd & hit_sh;
    end

    // every bank lets a set win over a clear in the same cycle, so a read
    // that meets a fresh fault never drops it
    // overload/heat flags latch in any driver state
    // only the write-one strobe clears them; a read leaves them standing
    flag_latch #(
        .WIDTH      (8)
    ) u_ovl (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .clk_en     (clk_en),
        .fault      (ovl_set),
        .clear      (ovl_clr),
        .flags      (ovl_flags)
    );

    // open load while off: latched only with the driver off
    // a read clears the whole register
    flag_latch #(
        .WIDTH      (8)
    ) u_off (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .clk_en     (clk_en),
        .fault      (off_set),
        .clear      (off_clr),
        .flags      (off_flags)
    );

    // open load while on: needs the driver on and its enable bit
    // a read clears the whole register
    flag_latch #(
        .WIDTH      (8)
    ) u_on (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .clk_en     (clk_en),
        .fault      (on_set),
        .clear      (on_clr),
        .flags      (on_flags)
    );

    // short to ground or battery, checked with the driver off
    // a read clears the whole register
    flag_latch #(
        .WIDTH      (8)
    ) u_sh (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .clk_en     (clk_en),
        .fault      (sh_set),
        .clear      (sh_clr),
        .flags      (sh_flags)
    );

    // enable register: plain read/write, changes only on a taken write
    always_comb begin
        en_nxt = en_r;
        if (req.wr && hit_en) begin
            en_nxt = req.wdata;
        end
    end

    // register the enable; reset is not gated by clk_en
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            en_r <= `FLAGS_RESET;
        end else if (clk_en) begin
            en_r <= en_nxt;
        end
    end

    // read answer: valid one cycle after a read, data zero when idle
    // status bit 1 mirrors any overload flag, bit 0 any off-state flag
    always_comb begin
        rvalid_nxt = req.rd;
        rdata_nxt  = 8'h00;
        if (req.rd) begin
            if (hit_ovl) begin
                rdata_nxt = ovl_flags;
            end else if (hit_off) begin
                rdata_nxt = off_flags;
            end else if (hit_on) begin
                rdata_nxt = on_flags;
            end else if (hit_sh) begin
                rdata_nxt = sh_flags;
            end else if (hit_en) begin
                rdata_nxt = en_r;
            end else if (hit_sta) begin
                rdata_nxt[`STATUS0_ON_ERR_BIT]  = |ovl_flags;
                rdata_nxt[`STATUS0_OFF_ERR_BIT] = |(off_flags | sh_flags);
            end else begin
                rdata_nxt = 8'h00; // unmapped offsets read as zero
            end
        end
    end

    // register the answer; a frozen clock holds it
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_r  <= `FLAGS_RESET;
            rvalid_r <= 1'b0;
        end else if (clk_en) begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // overload summary: any latched overload flag
    // the summary trails the flags by one cycle
    always_comb begin
        sum_nxt = |ovl_flags;
    end

    // register the summary; reset is not gated by clk_en
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sum_r <= 1'b0;
        end else if (clk_en) begin
            sum_r <= sum_nxt;
        end
    end

    // outputs straight from their registers
    assign rdata        = rdata_r;
    assign rvalid       = rvalid_r;
    assign any_overload = sum_r;
    assign ol_on_enable = en_r;
endmodule : fault_status_bank

// ---- tb/fault_bank_monitor.sv ----
// assertions on the register port of the fault status bank
// assumes binding to fault_status_bank
`timescale 1ns/1ps
module fault_bank_monitor (
    // clock and control
    input wire logic                      core_clk,
    input wire logic                      rstn,
    input wire logic                      clk_en,
    // watched signals
    input wire fault_bank_pkg::fault_in_s fault_in,
    input wire fault_bank_pkg::reg_req_s  req,
    input wire logic [7:0]                rdata,
    input wire logic                      rvalid,
    input wire logic                      any_overload,
    input wire fault_bank_pkg::chan_t     ol_on_enable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // requests that are taken
    wire rd = clk_en && req.rd;
    wire wr = clk_en && req.wr;
    a_read_answer: assert property (rd |=> rvalid)
        else $error("read not answered");
    a_no_stray: assert property (!rd && clk_en |=> !rvalid)
        else $error("stray read valid");
    a_idle_rdata: assert property (!rvalid |-> rdata == 8'h00)
        else $error("read data not idle");
    a_unmapped_zero: assert property (rd && req.addr > 8'h15 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_enable_write: assert property (wr && req.addr == 8'h0E |=> ol_on_enable == $past(req.wdata))
        else $error("enable write lost");
    a_enable_read: assert property (rd && req.addr == 8'h0E |=> rdata == $past(ol_on_enable))
        else $error("enable readback wrong");
    a_overload_set: assert property (clk_en && |fault_in.overload ##1 clk_en |=> any_overload)
        else $error("overload not flagged");
    a_overload_clear: assert property (wr && req.addr == 8'h0F && req.wdata == 8'hFF
        && fault_in.overload == 8'h00 ##1 clk_en && fault_in.overload == 8'h00 |=> !any_overload)
        else $error("overload clear failed");
    a_reset_clear: assert property (disable iff (1'b0) !rstn |=> !rvalid && !any_overload)
        else $error("reset did not clear");
endmodule : fault_bank_monitor
bind fault_status_bank fault_bank_monitor u_mon (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
    .fault_in(fault_in), .req(req), .rdata(rdata), .rvalid(rvalid),
    .any_overload(any_overload), .ol_on_enable(ol_on_enable));

// ---- tb/host_model.sv ----
// host side model issuing register reads and writes
// assumes requests change on the falling clock edge
`timescale 1ns/1ps
module host_model (
    // clock and answer
    input  wire logic                     core_clk,
    input  wire logic [7:0]               rdata,
    input  wire logic                     rvalid,
    // request
    output fault_bank_pkg::reg_req_s      req
);
    initial req = '0;
    // one request pulse; the answer stands for one cycle after the taking edge
    task automatic xfer(input logic rd, input logic [7:0] a, d, output logic [8:0] r);
        @(negedge core_clk) req = {rd, ~rd, a, d};
        @(negedge core_clk) begin
            r   = {rvalid, rdata};
            req = '0;
        end
    endtask : xfer
endmodule : host_model

// ---- tb/testbench.sv ----
// self-checking bench for the fault status bank
// assumes host_model drives the register port
`timescale 1ns/1ps
module testbench;
    logic                      core_clk, rstn, clk_en, rvalid, any_overload;
    fault_bank_pkg::fault_in_s fault_in;
    fault_bank_pkg::reg_req_s  req;
    fault_bank_pkg::chan_t     driver_on, ol_on_enable, p, d, e;
    logic [7:0]                rdata;
    logic [8:0]                r;
    logic [7:0]                regs [6] = '{8'h0E, 8'h10, 8'h12, 8'h13, 8'h14, 8'h15};
    int                        fail_count, checks_done, seed;
    fault_status_bank u_dut (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
        .fault_in(fault_in), .driver_on(driver_on), .req(req), .rdata(rdata),
        .rvalid(rvalid), .any_overload(any_overload), .ol_on_enable(ol_on_enable));
    host_model u_host (.core_clk(core_clk), .rdata(rdata), .rvalid(rvalid), .req(req));
    // expected flags of bank k
    function automatic logic [7:0] fexp(int k, logic [7:0] p, d, e);
        return k == 1 ? p & ~d : k == 2 ? p & d & e : p & ~d;
    endfunction : fexp
    // compare one value, count it, report a mismatch
    task automatic check8(input logic [8:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8
    // read one register and compare valid plus data
    task automatic rd(input logic [7:0] a, exp);
        u_host.xfer(1'b1, a, 8'h00, r);
        check8(r, {1'b1, exp});
    endtask : rd
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #8000 fail_count++;
        tally_and_finish;
    end
    // main sequence
    initial begin
        seed = 94;
        {rstn, clk_en, fault_in, driver_on} = '0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        clk_en = 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00);
        p = 8'($random(seed)) | 8'h80;
        d = 8'($random(seed));
        @(negedge core_clk) fault_in.overload = p;
        @(negedge core_clk) fault_in = '0;
        rd(8'h12, p);
        check8({8'h00, any_overload}, 9'h001);
        rd(8'h10, {6'h00, 1'b1, 1'b0});
        u_host.xfer(1'b0, 8'h0F, d, r);
        rd(8'h12, p & ~d);
        u_host.xfer(1'b0, 8'h0F, 8'hFF, r);
        fault_in.open_off = 8'hA5;
        rd(8'h13, 8'hA5);
        check8({8'h00, any_overload}, 9'h000);
        rd(8'h10, 8'h01);
        fault_in = '0;
        rd(8'h13, 8'hA5);
        rd(8'h13, 8'h00);
        for (int k = 1; k < 4; k++) begin
            {p, d, e} = 24'($random(seed));
            u_host.xfer(1'b0, 8'h0E, e, r);
            rd(8'h0E, e);
            check8({1'b0, ol_on_enable}, {1'b0, e});
            driver_on = d;
            @(negedge core_clk) fault_in = fault_bank_pkg::fault_in_s'(32'(p) << (8 * (3 - k)));
            @(negedge core_clk) fault_in = '0;
            rd(8'h12 + 8'(k), fexp(k, p, d, e));
            rd(8'h12 + 8'(k), 8'h00);
        end
        rd(8'h20, 8'h00);
        u_host.xfer(1'b0, 8'h13, 8'hFF, r);
        rd(8'h13, 8'h00);
        clk_en = 1'b0;
        @(negedge core_clk) fault_in.overload = 8'hFF;
        @(negedge core_clk) {clk_en, fault_in} = {1'b1, 32'h0};
        rd(8'h12, 8'h00);
        // mid-run reset clears latched flags, summary and enable
        @(negedge core_clk) fault_in.overload = 8'h3C;
        @(negedge core_clk) fault_in = '0;
        @(negedge core_clk) check8({8'h00, any_overload}, 9'h001);
        rstn = 1'b0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        check8({8'h00, any_overload}, 9'h000);
        rd(8'h12, 8'h00);
        rd(8'h0E, 8'h00);
        tally_and_finish;
    end
endmodule : testbench
